// ==== include/fsg_cfg.svh ====
// Offsets, field positions, reset values and map constants for the flash guard.
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH

// Register byte offsets on the 12-bit register bus.
`define FSG_AXI_AW        12
`define FSG_OFF_CFG       12'h000
`define FSG_OFF_STATUS    12'h004
`define FSG_OFF_RESULT    12'h008
`define FSG_OFF_ERASE_IDX 12'h00C
`define FSG_OFF_ERASE_BAS 12'h010

// Field positions and reset values.
`define FSG_FREEZE_BIT    0
`define FSG_ORG_LSB       1
`define FSG_DENS_BIT      3
`define FSG_PROT_EN_BIT   4
`define FSG_PROT_LSB      16
`define FSG_PERR_BIT      6
`define FSG_EERR_BIT      5
`define FSG_WIP_BIT       0
`define FSG_CFG_RESET     32'h0000_0000
`define FSG_RESP_OKAY     2'h0
`define FSG_RESP_SLVERR   2'h2

// Command codes seen on the serial link.
`define FSG_OP_IDENTIFICATION_READ_COMMAND       8'h9F
`define FSG_OP_PP         8'h02
`define FSG_OP_SE         8'hD8
`define FSG_OP_OTPP       8'h42
`define FSG_OP_OTPR       8'h4B

// Main array organisation.
`define FSG_SIZE_16MB     32'h0100_0000
`define FSG_SIZE_32MB     32'h0200_0000
`define FSG_SMALL_SPAN    32'h0002_0000
`define FSG_UNI_SHIFT     18
`define FSG_BIG_SHIFT     16
`define FSG_SMALL_SHIFT   12
`define FSG_UNI_MASK      32'hFFFC_0000
`define FSG_BIG_MASK      32'hFFFF_0000
`define FSG_SMALL_MASK    32'hFFFF_F000
// Thirty-two small sectors take the place of two 64 KB slots.
`define FSG_BOTTOM_BIG_1ST 10'h01E

// One-time space layout.
`define FSG_OTP_DEPTH     1024
`define FSG_OTP_RANDOM_N  10'h010
`define FSG_OTP_LOCK_BASE 10'h010
`define FSG_OTP_ERASED    8'hFF

`endif

// ==== include/fsg_pkg.sv ====
// Types shared by the flash guard modules.
`default_nettype none

package fsg_pkg;

  typedef enum logic [1:0] {ORG_UNIFORM, ORG_BOTTOM, ORG_TOP} fsg_org_type;

  typedef enum logic [1:0] {ST_IDLE, ST_MAP, ST_LOCK, ST_OREAD} fsg_state_type;

endpackage : fsg_pkg

`default_nettype wire

// ==== include/fsg_map_if.sv ====
// Interface between the command engine and the sector decoder.
`timescale 1ns/1ns
`default_nettype none

interface fsg_map_if;
  logic [31:0]          addr;
  fsg_pkg::fsg_org_type org;
  logic                 dens32;
  logic [9:0]           idx;
  logic [31:0]          base;

  modport user (output addr, output org, output dens32, input idx, input base);
  modport map  (input addr, input org, input dens32, output idx, output base);
endinterface : fsg_map_if

`default_nettype wire

// ==== include/fsg_otp_if.sv ====
// Interface between the command engine and the one-time byte store.
`timescale 1ns/1ns
`default_nettype none

interface fsg_otp_if;
  logic       en;
  logic       we;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport user (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface : fsg_otp_if

`default_nettype wire

// ==== logic/fsg_sector_map.sv ====
// Byte address to erase sector decoder for all organisations and densities.
`timescale 1ns/1ns
`default_nettype none
`include "fsg_cfg.svh"

module fsg_sector_map
  import fsg_pkg::*;
(
  // Decode request and answer
  fsg_map_if.map m
);

  logic [31:0] a;
  logic [31:0] top_start;

  always_comb begin
    a         = m.dens32 ? {7'h00, m.addr[24:0]} : {8'h00, m.addr[23:0]};
    top_start = (m.dens32 ? `FSG_SIZE_32MB : `FSG_SIZE_16MB) - `FSG_SMALL_SPAN;
    case (m.org)
      ORG_BOTTOM: begin
        if (a < `FSG_SMALL_SPAN) begin
          m.idx  = 10'(a >> `FSG_SMALL_SHIFT);
          m.base = a & `FSG_SMALL_MASK;
        end else begin
          m.idx  = 10'(a >> `FSG_BIG_SHIFT) + `FSG_BOTTOM_BIG_1ST;
          m.base = a & `FSG_BIG_MASK;
        end
      end
      ORG_TOP: begin
        if (a >= top_start) begin
          m.idx  = 10'(top_start >> `FSG_BIG_SHIFT) + 10'((a - top_start) >> `FSG_SMALL_SHIFT);
          m.base = a & `FSG_SMALL_MASK;
        end else begin
          m.idx  = 10'(a >> `FSG_BIG_SHIFT);
          m.base = a & `FSG_BIG_MASK;
        end
      end
      default: begin
        m.idx  = 10'(a >> `FSG_UNI_SHIFT);
        m.base = a & `FSG_UNI_MASK;
      end
    endcase
  end

endmodule : fsg_sector_map

`default_nettype wire

// ==== logic/fsg_otp_mem.sv ====
// One-time programmable byte store with factory random value and registered read.
`timescale 1ns/1ns
`default_nettype none
`include "fsg_cfg.svh"

module fsg_otp_mem
  import fsg_pkg::*;
#(
  parameter int           DEPTH        = `FSG_OTP_DEPTH,
  // Value is arbitrary; each part carries its own.
  parameter logic [127:0] RANDOM_VALUE = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  // Clock
  input wire logic aclk,
  // Store port
  fsg_otp_if.mem   p
);

  logic [7:0] cells [DEPTH];

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      cells[i] = `FSG_OTP_ERASED;
    end
  end

  // Cells only ever lose ones, as one-time cells do; reset leaves them alone.
  always_ff @(posedge aclk) begin
    if (p.en && p.we) begin
      cells[p.addr] <= cells[p.addr] & p.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (p.en) begin
      if (p.addr < `FSG_OTP_RANDOM_N) begin
        p.rdata <= RANDOM_VALUE[{p.addr[3:0], 3'b000} +: 8];
      end else begin
        p.rdata <= cells[p.addr];
      end
    end
  end

endmodule : fsg_otp_mem

`default_nettype wire

// ==== logic/fsg_flash_guard.sv ====
// Flash sector map, one-time space guard and register slave.
`timescale 1ns/1ns
`default_nettype none
`include "fsg_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Uniform: 256 KB sectors, 128 or 64.
// - Bottom 16 MB: 32x4 KB, then 64 KB.
// - Top 16 MB: 64 KB, then 32x4 KB.
// - Identification space is read only.
// - One-time space: 1024 bytes, 32 regions.
// - Lowest 16 bytes: factory random, unprogrammable.
// - Reserved bytes 14-1F stay programmable.
// - Delivered one-time bytes read FF.
// - Freeze bit blocks all one-time programming.
// - Freeze holds until power session ends.
// - 16 MB ignores address bits 31-24.
// - Protected program attempt sets program error.
////////////////////////////////////////////////////////////////////////////////

module fsg_flash_guard
  import fsg_pkg::*;
#(
  // Value is arbitrary; stands in for the identification contents.
  parameter logic [127:0] ID_DATA = 128'h5A5A_0001_0203_0405_0607_0809_0A0B_0C0D
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Register bus write channels
  input  wire logic [`FSG_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // Register bus read channels
  input  wire logic [`FSG_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Serial command link from the host controller
  input  wire logic                   sck,
  input  wire logic                   cs_n,
  input  wire logic                   mosi
);

  fsg_map_if map_bus ();
  fsg_otp_if otp_bus ();

  fsg_state_type st_q;
  logic [1:0]    sck_s_q;
  logic [1:0]    csn_s_q;
  logic [1:0]    mosi_s_q;
  logic          sck_old_q;
  logic          csn_old_q;
  logic [47:0]   sh_q;
  logic [5:0]    cnt_q;
  logic          sck_rise;
  logic          cs_rise;
  logic          go;
  logic [7:0]    go_op;
  logic [31:0]   go_addr;
  logic [7:0]    go_data;
  logic          otp_refused;
  logic [7:0]    op_q;
  logic [31:0]   addr_q;
  logic [7:0]    data_q;
  logic          lock_ok;
  logic          prot_hit;
  logic          perr_set;
  logic          eerr_set;
  logic          p_err_q;
  logic          e_err_q;
  logic [7:0]    result_q;
  logic [9:0]    erase_idx_q;
  logic [31:0]   erase_base_q;
  logic          freeze_q;
  fsg_org_type   org_q;
  logic          dens_q;
  logic          prot_en_q;
  logic [9:0]    prot_first_q;
  logic          aw_full_q;
  logic          w_full_q;
  logic [`FSG_AXI_AW-1:0] awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          aw_hs;
  logic          w_hs;
  logic          wr_do;
  logic          wr_ok;
  logic          ar_hs;
  logic [31:0]   rd_word;
  logic          rd_ok;

  fsg_sector_map u_map (
    .m (map_bus.map)
  );

  fsg_otp_mem u_otp (
    .aclk (aclk),
    .p    (otp_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Serial link capture. The link clock is slow against aclk, so it is sampled.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s_q   <= 2'h0;
      csn_s_q   <= 2'h3;
      mosi_s_q  <= 2'h0;
      sck_old_q <= 1'b0;
      csn_old_q <= 1'b1;
    end else begin
      sck_s_q   <= {sck_s_q[0], sck};
      csn_s_q   <= {csn_s_q[0], cs_n};
      mosi_s_q  <= {mosi_s_q[0], mosi};
      sck_old_q <= sck_s_q[1];
      csn_old_q <= csn_s_q[1];
    end
  end

  assign sck_rise = sck_s_q[1] && !sck_old_q;
  assign cs_rise  = csn_s_q[1] && !csn_old_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q  <= 48'h0000_0000_0000;
      cnt_q <= 6'h00;
    end else if (csn_s_q[1]) begin
      cnt_q <= 6'h00;
    end else if (sck_rise) begin
      sh_q <= {sh_q[46:0], mosi_s_q[1]};
      if (cnt_q != 6'h3F) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // A frame counts only when its length fits its command; others are dropped.
  always_comb begin
    go_op   = 8'h00;
    go_addr = 32'h0000_0000;
    go_data = 8'h00;
    go      = 1'b0;
    if (cnt_q == 6'h30) begin
      go_op   = sh_q[47:40];
      go_addr = sh_q[39:8];
      go_data = sh_q[7:0];
      go      = (go_op == `FSG_OP_PP) || (go_op == `FSG_OP_OTPP);
    end else if (cnt_q == 6'h28) begin
      go_op   = sh_q[39:32];
      go_addr = sh_q[31:0];
      go      = (go_op == `FSG_OP_SE) || (go_op == `FSG_OP_OTPR) || (go_op == `FSG_OP_IDENTIFICATION_READ_COMMAND);
    end
    go = go && cs_rise && (st_q == ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command engine.

  assign map_bus.addr   = addr_q;
  assign map_bus.org    = org_q;
  assign map_bus.dens32 = dens_q;

  assign prot_hit = prot_en_q && (map_bus.idx >= prot_first_q);

  assign lock_ok = otp_bus.rdata[addr_q[7:5]];

  assign otp_refused = freeze_q || (go_addr[31:10] != 22'h00_0000)
                       || (go_addr[9:0] < `FSG_OTP_RANDOM_N);

  always_comb begin
    otp_bus.en    = 1'b0;
    otp_bus.we    = 1'b0;
    otp_bus.addr  = addr_q[9:0];
    otp_bus.wdata = data_q;
    if (go && (go_op == `FSG_OP_OTPR)) begin
      otp_bus.en   = 1'b1;
      otp_bus.addr = go_addr[9:0];
    end else if (go && (go_op == `FSG_OP_OTPP) && !otp_refused) begin
      otp_bus.en   = 1'b1;
      otp_bus.addr = `FSG_OTP_LOCK_BASE + {8'h00, go_addr[9:8]};
    end else if ((st_q == ST_LOCK) && lock_ok) begin
      otp_bus.en = 1'b1;
      otp_bus.we = 1'b1;
    end
  end

  assign perr_set = (go && (go_op == `FSG_OP_OTPP) && otp_refused)
                    || ((st_q == ST_MAP) && (op_q == `FSG_OP_PP) && prot_hit)
                    || ((st_q == ST_LOCK) && !lock_ok);
  assign eerr_set = (st_q == ST_MAP) && (op_q == `FSG_OP_SE) && prot_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= ST_IDLE;
      op_q   <= 8'h00;
      addr_q <= 32'h0000_0000;
      data_q <= 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            op_q   <= go_op;
            addr_q <= go_addr;
            data_q <= go_data;
            if ((go_op == `FSG_OP_SE) || (go_op == `FSG_OP_PP)) begin
              st_q <= ST_MAP;
            end else if (go_op == `FSG_OP_OTPR) begin
              st_q <= ST_OREAD;
            end else if ((go_op == `FSG_OP_OTPP) && !otp_refused) begin
              st_q <= ST_LOCK;
            end
          end
        end
        ST_MAP:   st_q <= ST_IDLE;
        ST_LOCK:  st_q <= ST_IDLE;
        ST_OREAD: st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 8'h00;
    end else if (go && (go_op == `FSG_OP_IDENTIFICATION_READ_COMMAND)) begin
      result_q <= ID_DATA[{go_addr[3:0], 3'b000} +: 8];
    end else if (st_q == ST_OREAD) begin
      result_q <= (addr_q[31:10] == 22'h00_0000) ? otp_bus.rdata : `FSG_OTP_ERASED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_idx_q  <= 10'h000;
      erase_base_q <= 32'h0000_0000;
    end else if ((st_q == ST_MAP) && (op_q == `FSG_OP_SE) && !prot_hit) begin
      erase_idx_q  <= map_bus.idx;
      erase_base_q <= map_bus.base;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register slave. One write and one read in flight; unmapped words answer SLVERR.

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_ok = ({awaddr_q[`FSG_AXI_AW-1:2], 2'b00} == `FSG_OFF_CFG)
                 || ({awaddr_q[`FSG_AXI_AW-1:2], 2'b00} == `FSG_OFF_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_q      <= '0;
    end else if (aw_hs) begin
      aw_full_q     <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q      <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_full_q     <= 1'b0;
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_full_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q     <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
    end else if (w_hs) begin
      w_full_q     <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (wr_do) begin
      w_full_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= !w_full_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FSG_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `FSG_RESP_OKAY : `FSG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration fields; writes land only where byte strobes are set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      org_q        <= ORG_UNIFORM;
      dens_q       <= 1'(`FSG_CFG_RESET >> `FSG_DENS_BIT);
      prot_en_q    <= 1'b0;
      prot_first_q <= 10'h000;
    end else if (wr_do && ({awaddr_q[`FSG_AXI_AW-1:2], 2'b00} == `FSG_OFF_CFG)) begin
      if (wstrb_q[0]) begin
        org_q     <= fsg_org_type'(wdata_q[`FSG_ORG_LSB +: 2]);
        dens_q    <= wdata_q[`FSG_DENS_BIT];
        prot_en_q <= wdata_q[`FSG_PROT_EN_BIT];
      end
      if (wstrb_q[2]) begin
        prot_first_q[7:0] <= wdata_q[`FSG_PROT_LSB +: 8];
      end
      if (wstrb_q[3]) begin
        prot_first_q[9:8] <= wdata_q[`FSG_PROT_LSB + 8 +: 2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freeze_q <= 1'b0;
    end else if (wr_do && wstrb_q[0] && wdata_q[`FSG_FREEZE_BIT]
                 && ({awaddr_q[`FSG_AXI_AW-1:2], 2'b00} == `FSG_OFF_CFG)) begin
      freeze_q <= 1'b1;
    end
  end

  // Error flags: a new error in the clearing cycle wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_err_q <= 1'b0;
      e_err_q <= 1'b0;
    end else begin
      if (perr_set) begin
        p_err_q <= 1'b1;
      end else if (wr_do && wstrb_q[0] && wdata_q[`FSG_PERR_BIT]
                   && ({awaddr_q[`FSG_AXI_AW-1:2], 2'b00} == `FSG_OFF_STATUS)) begin
        p_err_q <= 1'b0;
      end
      if (eerr_set) begin
        e_err_q <= 1'b1;
      end else if (wr_do && wstrb_q[0] && wdata_q[`FSG_EERR_BIT]
                   && ({awaddr_q[`FSG_AXI_AW-1:2], 2'b00} == `FSG_OFF_STATUS)) begin
        e_err_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[`FSG_AXI_AW-1:2], 2'b00})
      `FSG_OFF_CFG: begin
        rd_word[`FSG_FREEZE_BIT]          = freeze_q;
        rd_word[`FSG_ORG_LSB +: 2]        = org_q;
        rd_word[`FSG_DENS_BIT]            = dens_q;
        rd_word[`FSG_PROT_EN_BIT]         = prot_en_q;
        rd_word[`FSG_PROT_LSB +: 10]      = prot_first_q;
      end
      `FSG_OFF_STATUS: begin
        rd_word[`FSG_PERR_BIT] = p_err_q;
        rd_word[`FSG_EERR_BIT] = e_err_q;
        rd_word[`FSG_WIP_BIT]  = (st_q != ST_IDLE);
      end
      `FSG_OFF_RESULT:    rd_word[7:0] = result_q;
      `FSG_OFF_ERASE_IDX: rd_word[9:0] = erase_idx_q;
      `FSG_OFF_ERASE_BAS: rd_word      = erase_base_q;
      default:            rd_ok        = 1'b0;
    endcase
  end

  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FSG_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? `FSG_RESP_OKAY : `FSG_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_otp_prog;
    (st_q == ST_IDLE) && go && (go_op == `FSG_OP_OTPP);
  endsequence

  sequence s_prot_prog;
    (st_q == ST_MAP) && (op_q == `FSG_OP_PP) && prot_hit;
  endsequence

  a_uniform_map: assert property (
    (st_q == ST_MAP) && (op_q == `FSG_OP_SE) && !prot_hit && (org_q == ORG_UNIFORM)
    |=> erase_idx_q == (dens_q ? {3'h0, addr_q[24:18]} : {4'h0, addr_q[23:18]}))
    else $error("uniform sector index wrong");

  a_bottom_big: assert property (
    (org_q == ORG_BOTTOM) && !dens_q && (addr_q[23:16] == 8'h02)
    |-> (map_bus.idx == 10'h020) && (map_bus.base == 32'h0002_0000))
    else $error("first big bottom sector misplaced");

  a_top_small: assert property (
    (org_q == ORG_TOP) && !dens_q && (addr_q[23:12] == 12'hFE0)
    |-> (map_bus.idx == 10'h0FE) && (map_bus.base == 32'h00FE_0000))
    else $error("first top small sector misplaced");

  a_id_readonly: assert property (
    (st_q == ST_IDLE) && go && (go_op == `FSG_OP_IDENTIFICATION_READ_COMMAND) |=> (!otp_bus.we)[*2])
    else $error("identification read wrote the store");

  a_random_guard: assert property (
    otp_bus.we |-> (otp_bus.addr >= `FSG_OTP_RANDOM_N) && (addr_q[31:10] == 22'h00_0000))
    else $error("random value bytes programmed");

  a_lock_block: assert property (
    (st_q == ST_LOCK) && !lock_ok |-> !otp_bus.we ##1 p_err_q)
    else $error("locked region programmed");

  a_freeze_block: assert property (
    s_otp_prog ##0 freeze_q |=> p_err_q && (st_q == ST_IDLE) ##1 !otp_bus.we)
    else $error("frozen space accepted program");

  a_freeze_hold: assert property (
    freeze_q |=> freeze_q)
    else $error("freeze dropped before reset");

  a_high_ignored: assert property (
    !dens_q |-> (map_bus.base[31:24] == 8'h00))
    else $error("high address bits decoded");

  a_prog_error: assert property (
    s_prot_prog |=> p_err_q && $stable(erase_base_q))
    else $error("protected program not flagged");

endmodule : fsg_flash_guard

`default_nettype wire

// ==== dv/fsg_host_model.sv ====
// Host controller model that sends serial command frames.
`timescale 1ns/1ns
`default_nettype none
module fsg_host_model (
  // Serial link
  output var logic sck,
  output var logic cs_n,
  output var logic mosi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // Mode 0: the clock idles low; data flips on release so stale bits never pass.
  task automatic send(input logic [47:0] f, input int n);
    #7 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = f[i];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    #20 cs_n = 1'b1;
    mosi = ~mosi;
  endtask : send
endmodule : fsg_host_model
`default_nettype wire

// ==== dv/fsg_flash_guard_tb_top.sv ====
// Self-checking bench for the flash guard.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module fsg_flash_guard_tb_top;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0]  br, rr;
  logic        awr, wr, bv, arr, rv;
  wire         sck, cs_n, mosi;
  int          n_mismatch = 0, samples_checked = 0;

  fsg_flash_guard dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .sck(sck), .cs_n(cs_n), .mosi(mosi));
  fsg_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    brd <= 1'b0;
    `CHK("bresp", 2'h0, br)
    // Let an edge pass so a following call never re-drives bready in this step.
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rrd <= 1'b0;
    `CHK("rdata", e, rd)
    `CHK("rresp", er, rr)
    @(posedge aclk);
  endtask : axr

  // Results settle a few cycles after the frame closes.
  task automatic op(input logic [47:0] f, input int n);
    host.send(f, n);
    repeat (12) @(posedge aclk);
  endtask : op

  task automatic obyte(input logic [9:0] a, input logic [7:0] e);
    op({16'h004B, 22'h0, a}, 40);
    axr(12'h008, {24'h0, e}, 2'h0);
  endtask : obyte

  task automatic prog(input logic [9:0] a, input logic [7:0] d);
    op({8'h42, 22'h0, a, d}, 48);
  endtask : prog

  task automatic stat(input logic [31:0] e);
    axr(12'h004, e, 2'h0);
    axw(12'h004, 32'h0000_0060);
  endtask : stat

  task automatic er(input logic [31:0] c, input logic [31:0] a, input logic [31:0] i,
                    input logic [31:0] b);
    axw(12'h000, c);
    op({16'h00D8, a}, 40);
    axr(12'h00C, i, 2'h0);
    axr(12'h010, b, 2'h0);
  endtask : er

  task automatic t_reset;
    axr(12'h000, 32'h0, 2'h0);
    axr(12'h004, 32'h0, 2'h0);
    axr(12'hFF0, 32'h0, 2'h2);
  endtask : t_reset

  task automatic t_read;
    op({16'h009F, 32'h0}, 40);
    axr(12'h008, 32'h0000_000D, 2'h0);
    obyte(10'h000, 8'h10);
    obyte(10'h00F, 8'h01);
    obyte(10'h010, 8'hFF);
    obyte(10'h3FF, 8'hFF);
  endtask : t_read

  task automatic t_lock;
    prog(10'h000, 8'h00);
    stat(32'h40);
    obyte(10'h000, 8'h10);
    prog(10'h020, 8'h5A);
    obyte(10'h020, 8'h5A);
    prog(10'h010, 8'hFD);
    prog(10'h020, 8'h00);
    stat(32'h40);
    obyte(10'h020, 8'h5A);
    prog(10'h014, 8'h0F);
    stat(32'h00);
    obyte(10'h014, 8'h0F);
  endtask : t_lock

  task automatic t_erase;
    er(32'h0, 32'hFF12_3456, 32'd4, 32'h0010_0000);
    er(32'h8, 32'h01FC_0001, 32'd127, 32'h01FC_0000);
    er(32'h2, 32'h0001_F123, 32'd31, 32'h0001_F000);
    er(32'h2, 32'h0002_0000, 32'd32, 32'h0002_0000);
    er(32'h4, 32'h00FD_FFFF, 32'd253, 32'h00FD_0000);
    er(32'h4, 32'h00FE_0123, 32'd254, 32'h00FE_0000);
    er(32'h4, 32'h00FF_FFFF, 32'd285, 32'h00FF_F000);
  endtask : t_erase

  task automatic t_guard;
    axw(12'h000, 32'h000A_0010);
    op({8'h02, 32'h002C_0000, 8'h00}, 48);
    stat(32'h40);
    // Protected erase: error flag set, last erase result left alone.
    er(32'h000A_0010, 32'h002C_0000, 32'd285, 32'h00FF_F000);
    stat(32'h20);
    axw(12'h000, 32'h1);
    prog(10'h040, 8'h00);
    stat(32'h40);
    obyte(10'h040, 8'hFF);
    axw(12'h000, 32'h0);
    axr(12'h000, 32'h1, 2'h0);
  endtask : t_guard

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_read();
    t_lock();
    t_erase();
    t_guard();
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end
endmodule : fsg_flash_guard_tb_top
`default_nettype wire
